//--- hw/fcc_pkg.sv
package fcc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int               ADDR_W      = 8;
   localparam logic [ADDR_W-1:0] RX_CTRL_OFS = 8'hc0;
   localparam logic [ADDR_W-1:0] TX_CTRL_OFS = 8'hc4;

   localparam int EN_BIT   = 31;
   localparam int RST_BIT  = 30;
   localparam int BAD_BIT  = 25;
   localparam int OVF_BIT  = 24;
   localparam int DROP_BIT = 23;
   localparam int DIS_BIT  = 20;

   // ----------------------------------------------------------------
   // Widths and sizes
   // ----------------------------------------------------------------
   localparam int USED_W = 16;
   localparam int LEN_W  = 16;
   localparam int SZ_W   = USED_W + 2;
   localparam int ERR_W  = 7;

   localparam int RX_CAP_DEF     = 12288;
   localparam int TX_CAP_DEF     = 12288;
   localparam int TX_MAX_DEF     = 2048;
   localparam int LENQ_DEPTH_DEF = 16;

   localparam logic [SZ_W-1:0]   WORD_PAD = 18'h00003;
   localparam logic [1:0]        HTRANS_BUSY_IDLE_MSB = 2'h2;

   // ----------------------------------------------------------------
   // State machines
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FCC_RX_IDLE  = 2'b00,
      FCC_RX_STORE = 2'b01,
      FCC_RX_SKIP  = 2'b10
   } fcc_rx_e;

   typedef enum logic {
      FCC_TX_IDLE = 1'b0,
      FCC_TX_SEND = 1'b1
   } fcc_tx_e;

   // Frame footprint: length padded to a whole word plus attached words
   function automatic logic [SZ_W-1:0] fcc_frame_size(input logic [LEN_W-1:0] len,
                                                      input logic [LEN_W-1:0] extra);
      logic [SZ_W-1:0] r;
      r = ({2'h0, len} + WORD_PAD) & ~WORD_PAD;
      return r + {2'h0, extra};
   endfunction

endpackage

//--- hw/fcc_lenq_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fcc_lenq_if #(parameter int DEPTH = fcc_pkg::LENQ_DEPTH_DEF);
   logic                        push;
   logic [fcc_pkg::SZ_W-1:0]    push_len;
   logic                        pop;
   logic                        clear;
   logic [fcc_pkg::SZ_W-1:0]    head;
   logic [$clog2(DEPTH):0]      count;
   logic                        full;

   modport ctl (output push, push_len, pop, clear, input head, count, full);
   modport mem (input push, push_len, pop, clear, output head, count, full);
endinterface
`default_nettype wire

//--- hw/fcc_lenq.sv
`timescale 1ns/10ps
`default_nettype none
module fcc_lenq #(
   parameter int DEPTH = fcc_pkg::LENQ_DEPTH_DEF
) (
   input  wire logic clock,
   input  wire logic rst_n,
   fcc_lenq_if.mem   q
);
   import fcc_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [SZ_W-1:0] mem_q [DEPTH];
   logic [AW-1:0]   wr_q;
   logic [AW-1:0]   rd_q;
   logic [AW:0]     count_d;
   logic            do_push;
   logic            do_pop;

   // Depth must be a power of two so the pointers wrap by themselves
   always_comb begin
      do_push = q.push && !q.full;
      do_pop  = q.pop && (q.count != '0);
      count_d = q.count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
   end

   always_ff @(posedge clock) begin
      if (do_push) begin
         mem_q[wr_q] <= q.push_len;
      end
   end

   // Head is registered, so it trails a pointer move by one cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q.head <= '0;
      end else begin
         q.head <= mem_q[rd_q];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || q.clear) begin
         wr_q    <= '0;
         rd_q    <= '0;
         q.count <= '0;
         q.full  <= 1'b0;
      end else begin
         if (do_push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (do_pop) begin
            rd_q <= rd_q + 1'b1;
         end
         q.count <= count_d;
         q.full  <= (count_d == (AW+1)'(DEPTH));
      end
   end

endmodule // fcc_lenq
`default_nettype wire

//--- hw/fcc_ctrl.sv
// Notes on behaviour
// - Receive enable set: accept frames from filter
// - Receive disabled: abort arriving frames, no writes
// - After enabling, store only whole next frame
// - Disable mid-frame: finish storing that frame first
// - Disabled-rejected frames do not count as dropped
// - Receive disabled flag on completion, write clears
// - Receive reset clears logic and pipeline leftovers
// - Store-bad-frames set: keep errored frames too
// - Any of seven MAC error causes marks bad
// - Receive dropped flag set on drop, write clears
// - Receive used bytes readable in low field
// - Used grows by padded length plus extra words
// - Transmit enable set: frames may go to MAC
// - Transmit disable lets current frame finish
// - Half duplex retry after disable: discard frame
// - Transmit reset clears logic and pipeline leftovers
// - Transmit disabled flag on completion, write clears
// - Transmit used bytes readable in low field
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module fcc_ctrl #(
   parameter int RX_CAP       = fcc_pkg::RX_CAP_DEF,
   parameter int TX_CAP       = fcc_pkg::TX_CAP_DEF,
   parameter int TX_MAX_FRAME = fcc_pkg::TX_MAX_DEF,
   parameter int LENQ_DEPTH   = fcc_pkg::LENQ_DEPTH_DEF
) (
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic                        hready,
   input  wire logic [31:0]                 hwdata,
   output var  logic [31:0]                 hrdata,
   output var  logic                        hreadyout,
   output var  logic                        hresp,
   input  wire logic                        rxf_sof,
   input  wire logic                        rxf_eof,
   input  wire logic [fcc_pkg::LEN_W-1:0]   rxf_len,
   input  wire logic [fcc_pkg::LEN_W-1:0]   rxf_extra,
   input  wire logic [fcc_pkg::ERR_W-1:0]   rxf_err,
   output var  logic                        rx_store,
   output var  logic                        rx_commit,
   output var  logic                        rx_abort,
   input  wire logic                        utx_pop,
   input  wire logic [fcc_pkg::USED_W-1:0]  utx_pop_bytes,
   output var  logic                        utx_flush,
   input  wire logic                        urx_push,
   input  wire logic [fcc_pkg::LEN_W-1:0]   urx_len,
   input  wire logic [fcc_pkg::LEN_W-1:0]   urx_extra,
   output var  logic                        urx_ready,
   output var  logic                        urx_flush,
   output var  logic                        mac_tx_valid,
   output var  logic [fcc_pkg::SZ_W-1:0]    mac_tx_bytes,
   input  wire logic                        mac_tx_start,
   input  wire logic                        mac_tx_done,
   input  wire logic                        mac_tx_retry,
   input  wire logic                        half_duplex,
   output var  logic                        mac_tx_discard
);
   import fcc_pkg::*;

   localparam logic [SZ_W-1:0] RX_CAP_L = SZ_W'(RX_CAP);
   localparam logic [SZ_W-1:0] TX_CAP_L = SZ_W'(TX_CAP);
   localparam logic [SZ_W-1:0] TX_MAX_L = SZ_W'(TX_MAX_FRAME);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic              ap;
   logic              wr_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic              wr_rx;
   logic              wr_tx;
   logic [31:0]       rd_word;
   logic [31:0]       hrdata_q;
   logic              hreadyout_q;
   logic              hresp_q;

   logic              rx_en_q, rx_bad_en_q, rx_ovf_q, rx_drop_q, rx_dis_q;
   logic              rx_rst_q, rx_pend_q;
   logic [USED_W-1:0] rx_used_q, rx_used_d;
   fcc_rx_e           rx_st_q, rx_st_d;
   logic [SZ_W-1:0]   rx_size;
   logic              rx_fit, rx_keep, rx_end, rx_ok, rx_ovf_set, rx_drop_set;
   logic              rx_refuse, rx_dis_set;
   logic              rx_store_q, rx_commit_q, rx_abort_q, utx_flush_q;

   logic              tx_en_q, tx_en_d, tx_dis_q, tx_rst_q, tx_pend_q;
   logic [USED_W-1:0] tx_used_q, tx_used_d;
   fcc_tx_e           tx_st_q, tx_st_d;
   logic [SZ_W-1:0]   tx_size;
   logic              tx_take, tx_start, tx_fin, tx_kill, tx_dis_set;
   logic              urx_ready_q, urx_flush_q, mac_tx_valid_q, mac_tx_discard_q;

   fcc_lenq_if #(.DEPTH(LENQ_DEPTH)) lq ();

   fcc_lenq #(.DEPTH(LENQ_DEPTH)) u_lenq (
      .clock (clock),
      .rst_n (rst_n),
      .q     (lq.mem)
   );

   // ----------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   // Read data are sampled at the address phase, so a read right behind
   // a write to the same register returns the value before that write.
   assign ap    = hsel && (htrans & HTRANS_BUSY_IDLE_MSB) != 2'h0 && hready;
   assign wr_rx = wr_q && (wr_addr_q == RX_CTRL_OFS);
   assign wr_tx = wr_q && (wr_addr_q == TX_CTRL_OFS);

   always_comb begin
      rd_word = 32'h0000_0000;
      case (haddr[ADDR_W-1:0])
         RX_CTRL_OFS: begin
            rd_word[EN_BIT]       = rx_en_q;
            rd_word[RST_BIT]      = rx_rst_q;
            rd_word[BAD_BIT]      = rx_bad_en_q;
            rd_word[OVF_BIT]      = rx_ovf_q;
            rd_word[DROP_BIT]     = rx_drop_q;
            rd_word[DIS_BIT]      = rx_dis_q;
            rd_word[USED_W-1:0]   = rx_used_q;
         end
         TX_CTRL_OFS: begin
            rd_word[EN_BIT]       = tx_en_q;
            rd_word[RST_BIT]      = tx_rst_q;
            rd_word[DIS_BIT]      = tx_dis_q;
            rd_word[USED_W-1:0]   = tx_used_q;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_q        <= 1'b0;
         wr_addr_q   <= '0;
         hrdata_q    <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else begin
         wr_q        <= ap && hwrite;
         wr_addr_q   <= haddr[ADDR_W-1:0];
         hrdata_q    <= (ap && !hwrite) ? rd_word : 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Receive control register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_en_q     <= 1'b0;
         rx_bad_en_q <= 1'b0;
         rx_rst_q    <= 1'b0;
         rx_pend_q   <= 1'b0;
      end else begin
         rx_rst_q <= wr_rx && hwdata[RST_BIT];
         if (wr_rx) begin
            rx_en_q     <= hwdata[EN_BIT];
            rx_bad_en_q <= hwdata[BAD_BIT];
         end
         if (wr_rx && rx_en_q && !hwdata[EN_BIT]) begin
            rx_pend_q <= 1'b1;
         end else if (rx_en_q || rx_dis_set) begin
            rx_pend_q <= 1'b0;
         end
      end
   end

   // Flags: a hardware set in the clearing cycle wins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_ovf_q  <= 1'b0;
         rx_drop_q <= 1'b0;
         rx_dis_q  <= 1'b0;
      end else begin
         if (rx_ovf_set) rx_ovf_q <= 1'b1;
         else if (wr_rx && hwdata[OVF_BIT]) rx_ovf_q <= 1'b0;
         if (rx_drop_set) rx_drop_q <= 1'b1;
         else if (wr_rx && hwdata[DROP_BIT]) rx_drop_q <= 1'b0;
         if (rx_dis_set) rx_dis_q <= 1'b1;
         else if (wr_rx && hwdata[DIS_BIT]) rx_dis_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Receive frame path
   // ----------------------------------------------------------------
   always_comb begin
      rx_size     = fcc_frame_size(rxf_len, rxf_extra);
      rx_fit      = ({2'h0, rx_used_q} + rx_size) <= RX_CAP_L;
      rx_keep     = (rxf_err == '0) || rx_bad_en_q;
      rx_end      = rxf_eof && (rx_st_q == FCC_RX_STORE) && !rx_rst_q;
      rx_ok       = rx_end && rx_keep && rx_fit;
      rx_ovf_set  = rx_end && rx_keep && !rx_fit;
      rx_drop_set = rx_end && !(rx_keep && rx_fit);
      // Frames refused while disabled never reach the dropped flag
      rx_refuse   = rxf_sof && (rx_st_q == FCC_RX_IDLE) && !rx_en_q && !rx_rst_q;
      rx_dis_set  = rx_pend_q && !rx_en_q && (rx_st_q != FCC_RX_STORE);
      rx_used_d   = rx_used_q;
      if (rx_ok) rx_used_d = rx_used_d + USED_W'(rx_size);
      if (utx_pop) rx_used_d = rx_used_d - utx_pop_bytes;
   end

   always_comb begin
      rx_st_d = rx_st_q;
      case (rx_st_q)
         FCC_RX_IDLE: begin
            // Only a start seen while enabled opens storing: no partial frames
            if (rxf_sof) rx_st_d = rx_en_q ? FCC_RX_STORE : FCC_RX_SKIP;
         end
         FCC_RX_STORE: begin
            if (rxf_eof) rx_st_d = FCC_RX_IDLE;
         end
         FCC_RX_SKIP: begin
            if (rxf_eof) rx_st_d = FCC_RX_IDLE;
         end
         default: rx_st_d = FCC_RX_IDLE;
      endcase
      if (rx_rst_q) rx_st_d = FCC_RX_IDLE;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_st_q     <= FCC_RX_IDLE;
         rx_store_q  <= 1'b0;
         rx_commit_q <= 1'b0;
         rx_abort_q  <= 1'b0;
         utx_flush_q <= 1'b0;
         rx_used_q   <= '0;
      end else begin
         rx_st_q     <= rx_st_d;
         rx_store_q  <= (rx_st_d == FCC_RX_STORE);
         rx_commit_q <= rx_ok;
         rx_abort_q  <= rx_refuse || rx_drop_set;
         utx_flush_q <= rx_rst_q;
         rx_used_q   <= rx_rst_q ? '0 : rx_used_d;
      end
   end

   // ----------------------------------------------------------------
   // Transmit control register
   // ----------------------------------------------------------------
   assign tx_en_d = wr_tx ? hwdata[EN_BIT] : tx_en_q;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_en_q   <= 1'b0;
         tx_rst_q  <= 1'b0;
         tx_pend_q <= 1'b0;
         tx_dis_q  <= 1'b0;
      end else begin
         tx_en_q  <= tx_en_d;
         tx_rst_q <= wr_tx && hwdata[RST_BIT];
         if (wr_tx && tx_en_q && !hwdata[EN_BIT]) begin
            tx_pend_q <= 1'b1;
         end else if (tx_en_q || tx_dis_set) begin
            tx_pend_q <= 1'b0;
         end
         if (tx_dis_set) tx_dis_q <= 1'b1;
         else if (wr_tx && hwdata[DIS_BIT]) tx_dis_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Transmit frame path
   // ----------------------------------------------------------------
   always_comb begin
      tx_size     = fcc_frame_size(urx_len, urx_extra);
      tx_take     = urx_push && urx_ready_q && !tx_rst_q;
      tx_start    = mac_tx_start && mac_tx_valid_q && (tx_st_q == FCC_TX_IDLE);
      tx_fin      = (tx_st_q == FCC_TX_SEND) && mac_tx_done;
      // A late retry is discarded only once the FIFO is disabled
      tx_kill     = (tx_st_q == FCC_TX_SEND) && mac_tx_retry && half_duplex
                    && !tx_en_q && !tx_fin;
      tx_dis_set  = tx_pend_q && !tx_en_q && (tx_st_q == FCC_TX_IDLE) && !tx_start;
      lq.push     = tx_take;
      lq.push_len = tx_size;
      lq.pop      = (tx_fin || tx_kill) && !tx_rst_q;
      lq.clear    = tx_rst_q;
      tx_used_d   = tx_used_q;
      if (tx_take) tx_used_d = tx_used_d + USED_W'(tx_size);
      if (lq.pop) tx_used_d = tx_used_d - USED_W'(lq.head);
   end

   always_comb begin
      tx_st_d = tx_st_q;
      case (tx_st_q)
         FCC_TX_IDLE: begin
            if (tx_start) tx_st_d = FCC_TX_SEND;
         end
         FCC_TX_SEND: begin
            if (tx_fin || tx_kill) tx_st_d = FCC_TX_IDLE;
         end
         default: tx_st_d = FCC_TX_IDLE;
      endcase
      if (tx_rst_q) tx_st_d = FCC_TX_IDLE;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_st_q          <= FCC_TX_IDLE;
         tx_used_q        <= '0;
         urx_ready_q      <= 1'b0;
         urx_flush_q      <= 1'b0;
         mac_tx_valid_q   <= 1'b0;
         mac_tx_discard_q <= 1'b0;
      end else begin
         tx_st_q          <= tx_st_d;
         tx_used_q        <= tx_rst_q ? '0 : tx_used_d;
         urx_flush_q      <= tx_rst_q;
         mac_tx_discard_q <= tx_kill;
         // Ready drops for a cycle after each take so room is re-checked
         urx_ready_q      <= !tx_rst_q && !tx_take && !lq.full
                             && ({2'h0, tx_used_q} + TX_MAX_L <= TX_CAP_L);
         // Head data trail a pop by a cycle, so valid waits one too
         mac_tx_valid_q   <= tx_en_d && (lq.count != '0) && (tx_st_d == FCC_TX_IDLE)
                             && !lq.pop && !tx_rst_q;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hrdata         = hrdata_q;
   assign hreadyout      = hreadyout_q;
   assign hresp          = hresp_q;
   assign rx_store       = rx_store_q;
   assign rx_commit      = rx_commit_q;
   assign rx_abort       = rx_abort_q;
   assign utx_flush      = utx_flush_q;
   assign urx_ready      = urx_ready_q;
   assign urx_flush      = urx_flush_q;
   assign mac_tx_valid   = mac_tx_valid_q;
   assign mac_tx_bytes   = lq.head;
   assign mac_tx_discard = mac_tx_discard_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_rx_refused;
      rxf_sof && rx_st_q == FCC_RX_IDLE && !rx_en_q && !rx_rst_q;
   endsequence

   sequence s_rx_aborted;
      rx_abort_q && !rx_store_q && !$rose(rx_drop_q);
   endsequence

   sequence s_tx_late_retry;
      tx_st_q == FCC_TX_SEND && mac_tx_retry && half_duplex && !tx_en_q && !mac_tx_done;
   endsequence

   chk_rx_refuse_off: assert property (s_rx_refused |=> s_rx_aborted)
      else $error("frame taken while receive disabled");
   chk_rx_take_on: assert property (rxf_sof && rx_st_q == FCC_RX_IDLE && rx_en_q
      && !rx_rst_q |=> rx_store_q)
      else $error("frame refused while receive enabled");
   chk_rx_no_partial: assert property (!rx_store_q && !rxf_sof |=> !rx_store_q)
      else $error("storing began without a frame start");
   chk_rx_finish_frame: assert property (rx_store_q && !rx_en_q && !rxf_eof
      && !rx_rst_q |=> rx_store_q && !$rose(rx_dis_q))
      else $error("disable cut a frame short");
   chk_rx_disable_flag: assert property ($fell(rx_en_q) && rx_st_q != FCC_RX_STORE
      && !rx_en_q |=> ##[0:1] rx_dis_q)
      else $error("receive disabled flag late");
   chk_bad_frame_drop: assert property (rx_end && rxf_err != '0 && !rx_bad_en_q
      |=> rx_drop_q && !rx_commit_q && rx_abort_q)
      else $error("bad frame kept");
   chk_bad_frame_keep: assert property (rx_end && rx_bad_en_q && rx_fit
      |=> rx_commit_q)
      else $error("bad frame not stored");
   chk_rx_used_grow: assert property (rx_ok && !utx_pop
      |=> rx_used_q == $past(rx_used_q) + USED_W'($past(rx_size)))
      else $error("used space grew wrongly");
   chk_rx_overflow: assert property (rx_end && rx_keep && !rx_fit
      |=> rx_ovf_q && rx_drop_q && ($stable(rx_used_q) || $past(utx_pop)))
      else $error("overflow not flagged");
   chk_rx_reset_clear: assert property (rx_rst_q |=> rx_used_q == '0 && utx_flush_q
      && !rx_store_q)
      else $error("receive reset incomplete");
   chk_flag_write_zero: assert property (wr_rx && !hwdata[OVF_BIT] && rx_ovf_q
      |=> rx_ovf_q)
      else $error("writing zero cleared a flag");
   chk_tx_valid_off: assert property (!tx_en_q && !wr_tx |=> !mac_tx_valid_q)
      else $error("frame offered while transmit disabled");
   chk_tx_finish_frame: assert property (tx_st_q == FCC_TX_SEND && !mac_tx_done
      && !mac_tx_retry && !tx_rst_q |=> tx_st_q == FCC_TX_SEND && !$rose(tx_dis_q))
      else $error("transmit frame cut short");
   chk_tx_retry_drop: assert property ((s_tx_late_retry and !tx_rst_q && !wr_tx)
      |=> mac_tx_discard_q && tx_st_q == FCC_TX_IDLE ##1 tx_dis_q)
      else $error("late retry not discarded");
   chk_tx_reset_clear: assert property (tx_rst_q |=> tx_used_q == '0 && urx_flush_q
      && lq.count == '0)
      else $error("transmit reset incomplete");
   chk_tx_disable_flag: assert property (tx_pend_q && !tx_en_q && tx_st_q == FCC_TX_IDLE
      && !tx_start |=> tx_dis_q)
      else $error("transmit disabled flag missing");

endmodule // fcc_ctrl
`default_nettype wire

//--- verification/fcc_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
module fcc_mac_model (
   input  wire logic       clock,
   input  wire logic [3:0] lat,
   input  wire logic       mac_tx_valid,
   output var  logic       mac_tx_start,
   output var  logic       mac_tx_done
);
   logic [3:0] cnt_q = 4'h0;
   initial {mac_tx_start, mac_tx_done} = 2'h0;
   // A busy MAC takes no second frame until the first is done
   always @(posedge clock) begin
      mac_tx_start <= mac_tx_valid === 1'b1 && cnt_q == 4'h0 && !mac_tx_start && !mac_tx_done;
      mac_tx_done <= cnt_q == 4'h1;
      if (mac_tx_start)
         cnt_q <= lat;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   end
endmodule // fcc_mac_model
`default_nettype wire

//--- verification/tb_ethernet_frame_fifo_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ethernet_frame_fifo_control;
   import fcc_pkg::*;
   localparam logic [31:0] EN = 32'h1 << EN_BIT, RS = 32'h1 << RST_BIT, SB = 32'h1 << BAD_BIT;
   localparam logic [31:0] DR = 32'h1 << DROP_BIT, DS = 32'h1 << DIS_BIT, OV = 32'h1 << OVF_BIT;
   logic        clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
   logic        rxf_sof = 1'b0, rxf_eof = 1'b0, urx_push = 1'b0;
   logic        mac_tx_retry = 1'b0, half_duplex = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [15:0] rxf_len = 16'h0, rxf_extra = 16'h0, urx_len = 16'h0, urx_extra = 16'h0, u, l, x;
   logic [6:0]  rxf_err = 7'h0;
   logic [3:0]  lat = 4'h8;
   logic        hreadyout, hresp, rx_store, rx_commit, rx_abort, utx_flush, urx_ready, urx_flush;
   logic        mac_tx_valid, mac_tx_start, mac_tx_done, mac_tx_discard;
   logic [17:0] mac_tx_bytes;
   logic [31:0] exp_q[$];
   int          err_count = 0, cmp_count = 0, commits = 0, flushes = 0, aborts = 0;
   int          discards = 0, n;
   fcc_ctrl i_fcc_ctrl (.*, .hready(hreadyout), .hsize(3'h2), .utx_pop(1'b0),
      .utx_pop_bytes(16'h0));
   fcc_mac_model i_fcc_mac_model (.*);
   initial forever #50 clock = ~clock;
   // ---------------------------
   // Checking and bus tasks
   // ---------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic results;
      $display("Compares %0d, errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic rdy;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         results;
      end
   endtask
   // On a read, d is the expected word; the monitor compares it
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) exp_q.push_back(d);
      rd_dp <= !w;
      rdy;
      rd_dp <= 1'b0;
   endtask
   task automatic sof;
      rxf_sof <= 1'b1;
      @(posedge clock);
      rxf_sof <= 1'b0;
      @(posedge clock);
   endtask
   task automatic eof(input logic [15:0] len, input logic [15:0] ex, input logic [6:0] er);
      rxf_eof <= 1'b1;
      rxf_len <= len;
      rxf_extra <= ex;
      rxf_err <= er;
      @(posedge clock);
      rxf_eof <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   function automatic logic [15:0] sz(input logic [15:0] a, input logic [15:0] b);
      return ((a + 16'h3) & ~16'h3) + b;
   endfunction
   always @(posedge clock) begin
      if (rst_n === 1'b1) begin
         commits += rx_commit;
         flushes += utx_flush + urx_flush;
         aborts += rx_abort;
         discards += mac_tx_discard;
      end
      if (rd_dp && hreadyout === 1'b1) chk(hrdata, exp_q.pop_front(), "hrdata");
      if (rd_dp) chk(hresp, 1'b0, "hresp");
   end
   initial begin
      void'($urandom(32'h7aa11111));
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      bus(1'b0, RX_CTRL_OFS, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      // Frame opened while disabled stays skipped though enabled mid-way
      sof;
      bus(1'b1, RX_CTRL_OFS, EN);
      eof(16'h40, 16'h0, 7'h0);
      chk(commits, 0, "commits");
      bus(1'b0, RX_CTRL_OFS, EN);
      l = 16'($urandom_range(60, 1));
      x = 16'($urandom_range(2, 0) * 4);
      sof;
      eof(l, x, 7'h0);
      u = sz(l, x);
      bus(1'b0, RX_CTRL_OFS, EN | u);
      sof;
      eof(16'h10, 16'h0, 7'h1 << $urandom_range(6, 0));
      bus(1'b0, RX_CTRL_OFS, EN | DR | u);
      bus(1'b1, RX_CTRL_OFS, EN);
      bus(1'b0, RX_CTRL_OFS, EN | DR | u);
      bus(1'b1, RX_CTRL_OFS, EN | DR);
      bus(1'b0, RX_CTRL_OFS, EN | u);
      bus(1'b1, RX_CTRL_OFS, EN | SB);
      sof;
      eof(16'h8, 16'h0, 7'h40);
      u = u + 16'h8;
      bus(1'b0, RX_CTRL_OFS, EN | SB | u);
      // Frame larger than the whole FIFO must overflow
      sof;
      eof(16'h4000, 16'h0, 7'h0);
      bus(1'b0, RX_CTRL_OFS, EN | SB | OV | DR | u);
      bus(1'b1, RX_CTRL_OFS, EN | SB | DR);
      bus(1'b0, RX_CTRL_OFS, EN | SB | OV | u);
      sof;
      bus(1'b1, RX_CTRL_OFS, 32'h0);
      eof(16'h5, 16'h4, 7'h0);
      u = u + 16'hc;
      bus(1'b0, RX_CTRL_OFS, DS | OV | u);
      bus(1'b1, RX_CTRL_OFS, DS | RS | OV);
      @(posedge clock);
      bus(1'b0, RX_CTRL_OFS, 32'h0);
      bus(1'b1, TX_CTRL_OFS, EN);
      l = 16'($urandom_range(40, 1));
      lat <= 4'($urandom_range(15, 10));
      urx_len <= l;
      urx_extra <= 16'h4;
      urx_push <= 1'b1;
      @(posedge clock);
      urx_push <= 1'b0;
      @(posedge clock);
      bus(1'b0, TX_CTRL_OFS, EN | sz(l, 16'h4));
      chk(mac_tx_bytes, sz(l, 16'h4), "tx bytes");
      bus(1'b1, TX_CTRL_OFS, 32'h0);
      for (n = 0; n < 50 && mac_tx_done !== 1'b1; n++) @(posedge clock);
      chk(n < 50, 1, "tx done");
      if (n >= 50) results;
      repeat (3) @(posedge clock);
      bus(1'b0, TX_CTRL_OFS, DS);
      bus(1'b1, TX_CTRL_OFS, DS | RS);
      @(posedge clock);
      bus(1'b0, TX_CTRL_OFS, 32'h0);
      chk(flushes, 2, "flushes");
      // Half duplex retry after disable: frame must be thrown away
      bus(1'b1, TX_CTRL_OFS, EN);
      urx_push <= 1'b1;
      @(posedge clock);
      urx_push <= 1'b0;
      for (n = 0; n < 50 && mac_tx_start !== 1'b1; n++) @(posedge clock);
      chk(n < 50, 1, "tx start");
      if (n >= 50) results;
      bus(1'b1, TX_CTRL_OFS, DS);
      half_duplex <= 1'b1;
      mac_tx_retry <= 1'b1;
      @(posedge clock);
      mac_tx_retry <= 1'b0;
      repeat (2) @(posedge clock);
      bus(1'b0, TX_CTRL_OFS, DS);
      chk(discards, 1, "discards");
      chk(aborts, 3, "aborts");
      results;
   end
endmodule // tb_ethernet_frame_fifo_control
`default_nettype wire
